// File: common/itp_pkg.sv
// Constants, types and register map of the two-wire target port
package itp_pkg;
    localparam int APB_AW = 8;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OWN = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_ACTION = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_RAW = 8'h14;
    localparam logic [7:0] ADDR_MIS = 8'h18;
    localparam logic [7:0] ADDR_CLR = 8'h1c;

    // Control register fields and register reset values
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_IRQ_EN_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [6:0] OWN_RST = 7'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Action codes
    localparam logic [1:0] ACTION_IDLE = 2'h0;
    localparam logic [1:0] ACTION_RECEIVE_REQUEST = 2'h1;
    localparam logic [1:0] ACTION_TRANSMIT_REQUEST = 2'h2;
    localparam logic [1:0] ACTION_FIRST_BYTE_RECEIVED = 2'h3;

    // Bits per byte on the wire
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Interrupt sources, bit 0 stop, bit 1 start, bit 2 data
    typedef struct packed {
        logic data;
        logic start;
        logic stop;
    } itp_irq_t;
    localparam itp_irq_t IRQ_RST = '{data: 1'b0, start: 1'b0, stop: 1'b0};

    // Bus pin pair
    typedef struct packed {
        logic scl;
        logic sda;
    } itp_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } itp_state_t;
endpackage

// File: logic/itp_sync.sv
// Two-flop synchroniser for the bus pins
`timescale 1ns/1ps
module itp_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pins in, synchronised out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // Idle bus lines are high, so reset to ones
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_r <= '1;
            sync_r <= '1;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

// File: logic/itp_target.sv
// Two-wire bus target port with APB registers and interrupt
`timescale 1ns/1ps
module itp_target (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [itp_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bus pins, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Interrupt
    output logic irq
);
    function automatic logic is_mapped(input logic [itp_pkg::APB_AW-1:0] a);
        is_mapped = (a == itp_pkg::ADDR_CTRL) || (a == itp_pkg::ADDR_OWN) ||
            (a == itp_pkg::ADDR_DATA) || (a == itp_pkg::ADDR_ACTION) ||
            (a == itp_pkg::ADDR_MASK) || (a == itp_pkg::ADDR_RAW) ||
            (a == itp_pkg::ADDR_MIS) || (a == itp_pkg::ADDR_CLR);
    endfunction
    // Pin synchronisation and edge detection
    itp_pkg::itp_pins_t pins_s;
    itp_pkg::itp_pins_t pins_q_r;
    logic scl_rise, scl_fall, start_det, stop_det;
    itp_sync #(.WIDTH(2)) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_s)
    );
    always_ff @(posedge clock) begin
        if (rst) begin
            pins_q_r <= '1;
        end else begin
            pins_q_r <= pins_s;
        end
    end

    assign scl_rise = pins_s.scl & ~pins_q_r.scl;
    assign scl_fall = ~pins_s.scl & pins_q_r.scl;
    assign start_det = pins_s.scl & pins_q_r.scl & pins_q_r.sda & ~pins_s.sda;
    assign stop_det = pins_s.scl & pins_q_r.scl & ~pins_q_r.sda & pins_s.sda;

    // APB phases
    logic apb_setup, apb_wr, apb_rd;
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pwrite;
    assign apb_rd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    // Register state
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [6:0] own_r, own_nxt;
    logic [7:0] tx_data_r, tx_data_nxt;
    itp_pkg::itp_irq_t status_r, status_nxt, mask_r, mask_nxt, clr_sel;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt, irq_r, irq_nxt;
    // Link state
    itp_pkg::itp_state_t state_r, state_nxt;
    logic [1:0] action_r, action_nxt;
    logic [7:0] sh_r, sh_nxt, rx_data_r, rx_data_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic rw_r, rw_nxt, first_r, first_nxt;
    logic sda_oe_r, sda_oe_nxt, scl_oe_r, scl_oe_nxt;
    logic start_ev, stop_ev, data_ev, tx_load, rx_read;
    logic target_en, irq_en;
    assign target_en = ctrl_r[itp_pkg::CTRL_EN_BIT];
    assign irq_en = ctrl_r[itp_pkg::CTRL_IRQ_EN_BIT];
    assign tx_load = apb_wr && paddr == itp_pkg::ADDR_DATA &&
        action_r == itp_pkg::ACTION_TRANSMIT_REQUEST;
    assign rx_read = apb_rd && paddr == itp_pkg::ADDR_DATA &&
        (action_r == itp_pkg::ACTION_RECEIVE_REQUEST ||
         action_r == itp_pkg::ACTION_FIRST_BYTE_RECEIVED);
    assign clr_sel = itp_pkg::itp_irq_t'(pwdata[2:0]);

    always_comb begin
        ctrl_nxt = ctrl_r;
        own_nxt = own_r;
        tx_data_nxt = tx_data_r;
        mask_nxt = mask_r;
        status_nxt = status_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (apb_setup) begin
            pslverr_nxt = ~is_mapped(paddr);
            prdata_nxt = 32'h0000_0000;
            if (pwrite) begin
                prdata_nxt = 32'h0000_0000;
            end else if (paddr == itp_pkg::ADDR_CTRL) begin
                prdata_nxt[1:0] = ctrl_r;
            end else if (paddr == itp_pkg::ADDR_OWN) begin
                prdata_nxt[6:0] = own_r;
            end else if (paddr == itp_pkg::ADDR_DATA) begin
                prdata_nxt[7:0] = rx_data_r;
            end else if (paddr == itp_pkg::ADDR_ACTION) begin
                prdata_nxt[1:0] = action_r;
            end else if (paddr == itp_pkg::ADDR_MASK) begin
                prdata_nxt[2:0] = mask_r;
            end else if (paddr == itp_pkg::ADDR_RAW) begin
                prdata_nxt[2:0] = status_r;
            end else if (paddr == itp_pkg::ADDR_MIS) begin
                prdata_nxt[2:0] = status_r & mask_r;
            end
        end
        if (apb_wr) begin
            if (paddr == itp_pkg::ADDR_CTRL) begin
                ctrl_nxt = pwdata[1:0];
            end else if (paddr == itp_pkg::ADDR_OWN) begin
                own_nxt = pwdata[6:0];
            end else if (paddr == itp_pkg::ADDR_DATA) begin
                tx_data_nxt = pwdata[7:0];
            end else if (paddr == itp_pkg::ADDR_MASK) begin
                mask_nxt = clr_sel;
            end else if (paddr == itp_pkg::ADDR_CLR) begin
                status_nxt = status_r & ~clr_sel;
            end
        end
        if (apb_rd && paddr == itp_pkg::ADDR_RAW) begin
            status_nxt = itp_pkg::IRQ_RST;
        end
        // New events win over any clear in the same cycle
        status_nxt = status_nxt | {data_ev, start_ev, stop_ev};
        irq_nxt = irq_en && (status_nxt & mask_nxt) != 3'h0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_r <= itp_pkg::CTRL_RST;
            own_r <= itp_pkg::OWN_RST;
            tx_data_r <= itp_pkg::DATA_RST;
            mask_r <= itp_pkg::IRQ_RST;
            status_r <= itp_pkg::IRQ_RST;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            own_r <= own_nxt;
            tx_data_r <= tx_data_nxt;
            mask_r <= mask_nxt;
            status_r <= status_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Link state machine
    always_comb begin
        state_nxt = state_r;
        action_nxt = rx_read ? itp_pkg::ACTION_IDLE : action_r;
        sh_nxt = sh_r;
        rx_data_nxt = rx_data_r;
        cnt_nxt = cnt_r;
        rw_nxt = rw_r;
        first_nxt = first_r;
        sda_oe_nxt = sda_oe_r;
        start_ev = 1'b0;
        stop_ev = 1'b0;
        if (!target_en) begin
            state_nxt = itp_pkg::ST_IDLE;
            action_nxt = itp_pkg::ACTION_IDLE;
            sda_oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
        end else if (start_det) begin
            state_nxt = itp_pkg::ST_ADDR;
            action_nxt = itp_pkg::ACTION_IDLE;
            start_ev = 1'b1;
            sda_oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
        end else if (stop_det) begin
            state_nxt = itp_pkg::ST_IDLE;
            action_nxt = itp_pkg::ACTION_IDLE;
            stop_ev = 1'b1;
            sda_oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
        end else begin
            case (state_r)
                itp_pkg::ST_ADDR, itp_pkg::ST_RX: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], pins_s.sda};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == itp_pkg::BYTE_BITS) begin
                        cnt_nxt = 4'h0;
                        if (state_r == itp_pkg::ST_RX) begin
                            rx_data_nxt = sh_r;
                            action_nxt = first_r ? itp_pkg::ACTION_FIRST_BYTE_RECEIVED
                                : itp_pkg::ACTION_RECEIVE_REQUEST;
                            first_nxt = 1'b0;
                            sda_oe_nxt = 1'b1;
                            state_nxt = itp_pkg::ST_RX_ACK;
                        end else if (sh_r[7:1] == own_r) begin
                            rw_nxt = sh_r[0];
                            sda_oe_nxt = 1'b1;
                            state_nxt = itp_pkg::ST_ADDR_ACK;
                        end else begin
                            state_nxt = itp_pkg::ST_IDLE;
                        end
                    end
                end
                itp_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        sda_oe_nxt = 1'b0;
                        first_nxt = 1'b1;
                        if (rw_r) begin
                            action_nxt = itp_pkg::ACTION_TRANSMIT_REQUEST;
                            state_nxt = itp_pkg::ST_TX;
                        end else begin
                            state_nxt = itp_pkg::ST_RX;
                        end
                    end
                end
                itp_pkg::ST_RX_ACK: begin
                    if (scl_fall) begin
                        sda_oe_nxt = 1'b0;
                        state_nxt = itp_pkg::ST_RX;
                    end
                end
                itp_pkg::ST_TX: begin
                    if (tx_load) begin
                        sh_nxt = pwdata[7:0];
                        sda_oe_nxt = ~pwdata[7];
                        action_nxt = itp_pkg::ACTION_IDLE;
                    end else if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == itp_pkg::BYTE_BITS) begin
                        cnt_nxt = 4'h0;
                        sda_oe_nxt = 1'b0;
                        state_nxt = itp_pkg::ST_TX_ACK;
                    end else if (scl_fall && action_r == itp_pkg::ACTION_IDLE) begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        sda_oe_nxt = ~sh_r[6];
                    end
                end
                itp_pkg::ST_TX_ACK: begin
                    // Ask only once the clock is low, so the load never moves data mid-high
                    if (scl_rise && pins_s.sda) begin
                        state_nxt = itp_pkg::ST_IDLE;
                    end else if (scl_rise) begin
                        cnt_nxt = 4'h1;
                    end else if (scl_fall && cnt_r == 4'h1) begin
                        cnt_nxt = 4'h0;
                        action_nxt = itp_pkg::ACTION_TRANSMIT_REQUEST;
                        state_nxt = itp_pkg::ST_TX;
                    end
                end
                default: begin
                    state_nxt = itp_pkg::ST_IDLE;
                end
            endcase
        end
        data_ev = action_r == itp_pkg::ACTION_IDLE &&
            action_nxt != itp_pkg::ACTION_IDLE;
        // Hold the clock low while software owes an answer
        scl_oe_nxt = target_en && action_nxt != itp_pkg::ACTION_IDLE && ~pins_s.scl;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= itp_pkg::ST_IDLE;
            action_r <= itp_pkg::ACTION_IDLE;
            sh_r <= 8'h00;
            rx_data_r <= itp_pkg::DATA_RST;
            cnt_r <= 4'h0;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            action_r <= action_nxt;
            sh_r <= sh_nxt;
            rx_data_r <= rx_data_nxt;
            cnt_r <= cnt_nxt;
            rw_r <= rw_nxt;
            first_r <= first_nxt;
            sda_oe_r <= sda_oe_nxt;
            scl_oe_r <= scl_oe_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_rx_byte;
        target_en && !start_det && !stop_det && state_r == itp_pkg::ST_RX &&
            scl_fall && cnt_r == itp_pkg::BYTE_BITS;
    endsequence
    sequence s_data_read;
        apb_setup && !pwrite && paddr == itp_pkg::ADDR_DATA ##1 apb_rd;
    endsequence
    a_disabled_quiet: assert property (!target_en |=> !sda_oe && !scl_oe &&
        action_r == itp_pkg::ACTION_IDLE)
        else $error("disabled target still drives the bus");
    a_addr_mismatch: assert property (target_en && !start_det && !stop_det &&
        state_r == itp_pkg::ST_ADDR && scl_fall && cnt_r == itp_pkg::BYTE_BITS &&
        sh_r[7:1] != own_r |=> state_r == itp_pkg::ST_IDLE && !sda_oe)
        else $error("foreign address answered");
    a_start_flag: assert property (target_en && start_det |=> status_r.start)
        else $error("start not flagged");
    a_mask_irq: assert property (irq_en && (status_r & mask_r) != 3'h0 &&
        !psel |=> irq)
        else $error("unmasked pending source without interrupt");
    a_clear_subset: assert property (apb_wr && paddr == itp_pkg::ADDR_CLR &&
        pwdata[1] && !(target_en && start_det) |=> !status_r.start)
        else $error("cleared source still pending");
    a_global_off: assert property (!irq_en ##1 !irq_en |-> !irq)
        else $error("interrupt with overall enable off");
    a_stop_idle: assert property (target_en && stop_det |=>
        action_r == itp_pkg::ACTION_IDLE && status_r.stop)
        else $error("stop left an action pending");
    a_rx_code: assert property (s_rx_byte |=>
        (action_r == itp_pkg::ACTION_RECEIVE_REQUEST ||
         action_r == itp_pkg::ACTION_FIRST_BYTE_RECEIVED) && status_r.data && sda_oe)
        else $error("received byte not reported");
    a_tx_load: assert property (target_en && !start_det && !stop_det &&
        tx_load && state_r == itp_pkg::ST_TX |=> action_r == itp_pkg::ACTION_IDLE &&
        sh_r == $past(pwdata[7:0]) && sda_oe == ~$past(pwdata[7]))
        else $error("transmit byte not loaded");
    a_data_read: assert property (s_data_read |-> prdata[7:0] == $past(rx_data_r))
        else $error("data read does not return received byte");
endmodule

// File: tb/itp_ctl_model.sv
// Behavioural two-wire bus controller that drives the target port
`timescale 1ns/1ps
module itp_ctl_model (
    // Clock
    input wire logic clock,
    // Resolved wire levels
    input wire logic scl_w,
    input wire logic sda_w,
    // Pull-downs and stall flag
    output logic scl_low,
    output logic sda_low,
    output logic hung
);
    localparam int HALF = 8;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        hung = 1'b0;
    end
    task automatic pause(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Releases the clock and waits out a stretch by the target, raising hung after 4000 cycles
    task automatic rise();
        int n;
        n = 0;
        scl_low <= 1'b0;
        @(posedge clock);
        while (scl_w !== 1'b1 && n < 4000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 4000) hung <= 1'b1;
    endtask
    // Data moves only while the clock is low, sampled mid-high
    task automatic bit_io(input logic o, output logic i);
        pause(2);
        sda_low <= ~o;
        pause(HALF);
        rise();
        pause(HALF / 2);
        i = sda_w;
        pause(HALF / 2);
        scl_low <= 1'b1;
    endtask
    task automatic start();
        sda_low <= 1'b1;
        pause(HALF);
        scl_low <= 1'b1;
    endtask
    task automatic stop();
        pause(2);
        sda_low <= 1'b1;
        pause(HALF);
        rise();
        pause(HALF);
        sda_low <= 1'b0;
        pause(HALF);
    endtask
    // Most significant bit first; the ninth clock carries the reply
    task automatic send(input logic [7:0] b, output logic acked);
        logic d;
        for (int k = 7; k >= 0; k--) bit_io(b[k], d);
        bit_io(1'b1, d);
        acked = ~d;
    endtask
    task automatic fetch(input logic ack, output logic [7:0] b);
        logic d;
        for (int k = 7; k >= 0; k--) bit_io(1'b1, b[k]);
        bit_io(~ack, d);
    endtask
endmodule

// File: tb/i2c_target_port_tb_top.sv
// Self-checking bench for the two-wire target port
`timescale 1ns/1ps
module i2c_target_port_tb_top;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic scl_out, scl_oe, sda_out, sda_oe, m_scl_low, m_sda_low, hung, scl_w, sda_w;
    logic a0, a1, a2;
    logic [6:0] own;
    logic [7:0] b0, b1, r0, r1;
    int num_errors, total_checks, seed;

    // Open-drain wires with pull-ups
    assign scl_w = (scl_oe ? scl_out : 1'b1) & ~m_scl_low;
    assign sda_w = (sda_oe ? sda_out : 1'b1) & ~m_sda_low;

    itp_target dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
    itp_ctl_model m (.clock(clock), .scl_w(scl_w), .sda_w(sda_w), .scl_low(m_scl_low),
        .sda_low(m_sda_low), .hung(hung));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data taken at the edge that sees pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            end_sim();
        end
    endtask
    task automatic wait_act();
        int n;
        n = 0;
        do begin
            apb(1'b0, itp_pkg::ADDR_ACTION, 32'h0);
            n++;
        end while (q[1:0] === 2'h0 && n < 600);
        if (n >= 600) begin
            num_errors++;
            end_sim();
        end
    endtask
    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, {31'h0, exp});
    endtask
    function automatic logic [31:0] st(input logic d, input logic s, input logic p);
        return {29'h0, d, s, p};
    endfunction
    function automatic logic [31:0] act(input logic [1:0] c);
        return {30'h0, c};
    endfunction

    always @(posedge hung) begin
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (100000) @(posedge clock);
        num_errors++;
        end_sim();
    end

    initial begin
        num_errors = 0;
        total_checks = 0;
        seed = 2;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk(q, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, pslverr}, 32'h1);
        $display("test reset done");
        own = 7'($random(seed));
        b0 = 8'($random(seed));
        b1 = 8'($random(seed));
        apb(1'b1, itp_pkg::ADDR_OWN, {25'h0, own});
        apb(1'b1, itp_pkg::ADDR_MASK, 32'h7);
        m.start();
        m.send({own, 1'b0}, a0);
        m.stop();
        chk({31'h0, a0}, 32'h0);
        apb(1'b0, itp_pkg::ADDR_RAW, 32'h0);
        chk(q, 32'h0);
        $display("test disabled done");
        apb(1'b1, itp_pkg::ADDR_CTRL, 32'h3);
        m.start();
        m.send({own ^ 7'h01, 1'b0}, a0);
        m.stop();
        chk({31'h0, a0}, 32'h0);
        apb(1'b0, itp_pkg::ADDR_ACTION, 32'h0);
        chk(q, act(itp_pkg::ACTION_IDLE));
        apb(1'b0, itp_pkg::ADDR_RAW, 32'h0);
        chk(q, st(1'b0, 1'b1, 1'b1));
        $display("test mismatch done");
        fork
            begin
                m.start();
                m.send({own, 1'b0}, a0);
                m.send(b0, a1);
                m.send(b1, a2);
                m.stop();
            end
            begin
                wait_act();
                chk(q, act(itp_pkg::ACTION_FIRST_BYTE_RECEIVED));
                chk_irq(1'b1);
                apb(1'b0, itp_pkg::ADDR_DATA, 32'h0);
                chk(q, {24'h0, b0});
                wait_act();
                chk(q, act(itp_pkg::ACTION_RECEIVE_REQUEST));
                apb(1'b0, itp_pkg::ADDR_DATA, 32'h0);
                chk(q, {24'h0, b1});
            end
        join
        chk({29'h0, a0, a1, a2}, 32'h7);
        apb(1'b0, itp_pkg::ADDR_MIS, 32'h0);
        chk(q, st(1'b1, 1'b1, 1'b1));
        $display("test write done");
        apb(1'b1, itp_pkg::ADDR_MASK, 32'h1);
        apb(1'b0, itp_pkg::ADDR_MIS, 32'h0);
        chk(q, st(1'b0, 1'b0, 1'b1));
        chk_irq(1'b1);
        apb(1'b1, itp_pkg::ADDR_MASK, 32'h0);
        chk_irq(1'b0);
        apb(1'b1, itp_pkg::ADDR_MASK, 32'h7);
        apb(1'b1, itp_pkg::ADDR_CTRL, 32'h1);
        chk_irq(1'b0);
        apb(1'b1, itp_pkg::ADDR_CTRL, 32'h3);
        chk_irq(1'b1);
        apb(1'b1, itp_pkg::ADDR_CLR, 32'h5);
        apb(1'b0, itp_pkg::ADDR_MIS, 32'h0);
        chk(q, st(1'b0, 1'b1, 1'b0));
        apb(1'b0, itp_pkg::ADDR_RAW, 32'h0);
        chk(q, st(1'b0, 1'b1, 1'b0));
        apb(1'b0, itp_pkg::ADDR_RAW, 32'h0);
        chk(q, 32'h0);
        chk_irq(1'b0);
        $display("test interrupt done");
        fork
            begin
                m.start();
                m.send({own, 1'b1}, a0);
                m.fetch(1'b1, r0);
                m.fetch(1'b0, r1);
                m.stop();
            end
            begin
                wait_act();
                chk(q, act(itp_pkg::ACTION_TRANSMIT_REQUEST));
                apb(1'b1, itp_pkg::ADDR_DATA, {24'h0, b1});
                wait_act();
                chk(q, act(itp_pkg::ACTION_TRANSMIT_REQUEST));
                apb(1'b1, itp_pkg::ADDR_DATA, {24'h0, b0});
            end
        join
        chk({16'h0, r0, r1}, {16'h0, b1, b0});
        chk({31'h0, a0}, 32'h1);
        apb(1'b0, itp_pkg::ADDR_ACTION, 32'h0);
        chk(q, act(itp_pkg::ACTION_IDLE));
        $display("test read done");
        apb(1'b0, itp_pkg::ADDR_RAW, 32'h0);
        apb(1'b1, itp_pkg::ADDR_CTRL, 32'h2);
        m.start();
        m.send({own, 1'b0}, a0);
        m.stop();
        chk({31'h0, a0}, 32'h0);
        apb(1'b0, itp_pkg::ADDR_RAW, 32'h0);
        chk(q, 32'h0);
        $display("test disable again done");
        end_sim();
    end
endmodule
